// [src/rinit_seq.sv]
// reset initialization sequencer top
// Summary of operation
// - outputs asserted at least 512 sync periods, hard released at least 16 before soft
// - strap set is three-bit boot source plus one divide select
// - strap pin drivers turn off as soon as own hard reset asserts, one clock after a pin hard reset is sensed
// - strap drivers resume only after soft reset release, two sync periods into run
// - host mode sync clock derived from input clock by divide strap
// - input clock timing applies in host mode only, else sync clock
// - wait up to 100 us for pll lock
// - dll lock wait 7680 to 122880 bus cycles, scaled by ratio
// - reset pins driven low only, open drain, also sensed as inputs
module rinit_seq (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic host_mode_i,
  input wire logic [1:0] dll_ratio_sel_i,
  input wire logic pll_locked_i,
  input wire logic dll_locked_i,
  input wire rinit_pkg::rinit_strap_type strap_i,
  input wire rinit_pkg::rinit_rst_type rst_pin_i,
  output logic hard_reset_n_oe_o,
  output logic soft_reset_n_oe_o,
  output logic strap_drive_en_o,
  output logic sync_tick_o,
  output rinit_pkg::rinit_strap_type strap_o,
  output logic system_ready_o
);
  import rinit_pkg::*;

  typedef struct packed {
    rinit_state_type st;
    logic [CNT_W-1:0] cnt;
    logic [3:0] div;
    logic [5:0] hin_cnt;
    logic [5:0] sin_cnt;
    logic [2:0] hsync;
    logic [2:0] ssync;
    logic drv_hard;
    logic drv_soft;
    logic strap_en;
    logic tick;
    rinit_strap_type strap;
  } rinit_reg_type;

  rinit_reg_type r_q, r_d;

  // decoded dll wait from ratio, 2:1 min and 8:1 max
  function automatic logic [CNT_W-1:0] dll_wait(input logic [1:0] sel);
    case (sel)
      2'h0: dll_wait = CNT_W'(DLL_LOCK_MIN_CYC);
      2'h1: dll_wait = CNT_W'(DLL_LOCK_MIN_CYC * 4);
      2'h2: dll_wait = CNT_W'(DLL_LOCK_MIN_CYC * 8);
      default: dll_wait = CNT_W'(DLL_LOCK_MAX_CYC);
    endcase
  endfunction

  logic h_low, s_low, in_hard_req, in_soft_req;

  always_comb begin
    r_d = r_q;
    // divider for sync clock tick; agent mode uses every edge
    r_d.tick = 1'b0;
    if (!host_mode_i) begin
      r_d.tick = 1'b1;
    end else if (r_q.div >= (r_q.strap.input_clock_divide_select ? 4'h1 : 4'h0)) begin
      r_d.div = 4'h0;
      r_d.tick = 1'b1;
    end else begin
      r_d.div = r_q.div + 4'h1;
    end
    // pin sensing, three stage, second and third agree
    r_d.hsync = {r_q.hsync[1:0], rst_pin_i.hard_n};
    r_d.ssync = {r_q.ssync[1:0], rst_pin_i.soft_n};
    h_low = (r_q.hsync[2:1] == 2'h0) && !r_q.drv_hard;
    s_low = (r_q.ssync[2:1] == 2'h0) && !r_q.drv_soft;
    if (!h_low) r_d.hin_cnt = 6'h0;
    else if (r_q.tick && r_q.hin_cnt != 6'h3f) r_d.hin_cnt = r_q.hin_cnt + 6'h1;
    if (!s_low) r_d.sin_cnt = 6'h0;
    else if (r_q.tick && r_q.sin_cnt != 6'h3f) r_d.sin_cnt = r_q.sin_cnt + 6'h1;
    in_hard_req = r_q.hin_cnt >= 6'(IN_RESET_MIN_SYNC);
    in_soft_req = r_q.sin_cnt >= 6'(IN_RESET_MIN_SYNC);
    case (r_q.st)
      RINIT_POR: begin
        // straps sampled on first edge after power-on release
        r_d.strap = strap_i;
        r_d.cnt = '0;
        r_d.st = RINIT_PLL;
      end
      RINIT_PLL: begin
        r_d.cnt = r_q.cnt + 1'b1;
        if (pll_locked_i || r_q.cnt >= CNT_W'(PLL_LOCK_CYC - 1)) begin
          r_d.cnt = '0;
          r_d.st = RINIT_DLL;
        end
      end
      RINIT_DLL: begin
        r_d.cnt = r_q.cnt + 1'b1;
        if (dll_locked_i || r_q.cnt >= dll_wait(dll_ratio_sel_i) - 1'b1) begin
          r_d.cnt = '0;
          r_d.st = RINIT_ASSERT;
        end
      end
      RINIT_ASSERT: begin
        r_d.drv_hard = 1'b1;
        r_d.drv_soft = 1'b1;
        if (r_q.tick) r_d.cnt = r_q.cnt + 1'b1;
        if (r_q.tick && r_q.cnt >= CNT_W'(OUT_ASSERT_MIN_SYNC)) begin
          r_d.drv_hard = 1'b0;
          r_d.cnt = '0;
          r_d.st = RINIT_SOFT;
        end
      end
      RINIT_SOFT: begin
        if (r_q.tick) r_d.cnt = r_q.cnt + 1'b1;
        if (r_q.tick && r_q.cnt >= CNT_W'(HARD_TO_SOFT_SYNC)) begin
          r_d.drv_soft = 1'b0;
          r_d.cnt = '0;
          r_d.st = RINIT_RUN;
        end
      end
      RINIT_RUN: begin
        // strap drivers back on after two sync periods of released hard reset
        if (r_q.tick && !h_low && r_q.hsync[2:1] == 2'h3 && r_q.cnt < CNT_W'(STRAP_TURNON_SYNC + 1))
          r_d.cnt = r_q.cnt + 1'b1;
        if (r_q.cnt >= CNT_W'(STRAP_TURNON_SYNC + 1)) r_d.strap_en = 1'b1;
        if (in_hard_req || in_soft_req) begin
          r_d.cnt = '0;
          r_d.strap_en = 1'b0;
          r_d.st = RINIT_ASSERT;
        end
      end
      default: r_d.st = RINIT_POR;
    endcase
    // own hard drive drops strap drivers at once, a sensed pin hard reset on the next edge; straps stay latched
    if (r_d.drv_hard || h_low) r_d.strap_en = 1'b0;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r_q <= '{st: RINIT_POR, cnt: '0, div: 4'h0, hin_cnt: 6'h0, sin_cnt: 6'h0,
               hsync: 3'h7, ssync: 3'h7, drv_hard: 1'b1, drv_soft: 1'b1,
               strap_en: 1'b0, tick: 1'b0,
               strap: '{boot_source: BOOT_RESET_VAL, input_clock_divide_select: 1'b0}};
    end else begin
      r_q <= r_d;
    end
  end

  // open drain: enable low means driving low
  assign hard_reset_n_oe_o = !r_q.drv_hard;
  assign soft_reset_n_oe_o = !r_q.drv_soft;
  // combinational off path keeps turn-off well inside a few ns
  assign strap_drive_en_o = r_q.strap_en && !r_q.drv_hard && !r_d.drv_hard;
  assign sync_tick_o = r_q.tick;
  assign strap_o = r_q.strap;
  assign system_ready_o = (r_q.st == RINIT_RUN) && !r_q.drv_soft;

  a_hard_before_soft: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(hard_reset_n_oe_o) |-> !soft_reset_n_oe_o) else $error("hard release order");
  a_soft_gap: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(hard_reset_n_oe_o) && host_mode_i == 1'b0 |-> !soft_reset_n_oe_o [*8]) else $error("soft too soon");
  a_strap_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !hard_reset_n_oe_o |-> !strap_drive_en_o) else $error("strap drive in reset");
  a_strap_wait: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(hard_reset_n_oe_o) |-> !strap_drive_en_o [*2]) else $error("strap on early");
  a_strap_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r_q.st != RINIT_POR |=> $stable(strap_o)) else $error("strap changed");
  // tick register leaves reset low, so the first edge after release is excused
  a_agent_tick: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !host_mode_i && !$past(host_mode_i) && $past(resetn_i) |-> sync_tick_o) else $error("agent tick");
  a_div_tick: assert property (@(posedge clk_i) disable iff (!resetn_i)
    host_mode_i && strap_o.input_clock_divide_select && sync_tick_o && $past(host_mode_i) |=> !sync_tick_o)
    else $error("divide tick");
  // the wait counter itself bounds the pll wait; a delay range would be too long
  a_pll_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r_q.st == RINIT_PLL |-> r_q.cnt < CNT_W'(PLL_LOCK_CYC)) else $error("pll wait");
  a_pll_lock: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r_q.st == RINIT_PLL && pll_locked_i |=> r_q.st == RINIT_DLL) else $error("pll lock ignored");
  a_in_req: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r_q.st == RINIT_RUN && r_q.hin_cnt < 6'd31 && r_q.sin_cnt < 6'd31 |=> r_q.st == RINIT_RUN)
    else $error("short pulse honoured");
  // an unlocked dll may take the whole decoded wait, so only a lock ends it early
  a_dll_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r_q.st == RINIT_DLL && dll_locked_i
    |=> r_q.st != RINIT_DLL) else $error("dll wait");
  a_dll_limit: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r_q.st == RINIT_DLL |-> r_q.cnt < dll_wait(dll_ratio_sel_i)) else $error("dll wait too long");

  // soft reset is never released while hard reset is still driven
  a_soft_covers: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !hard_reset_n_oe_o |-> !soft_reset_n_oe_o) else $error("soft released first");
  // hard release only after the full assertion count of sync ticks
  a_hard_span: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(hard_reset_n_oe_o) |-> $past(r_q.cnt) >= CNT_W'(OUT_ASSERT_MIN_SYNC))
    else $error("hard span short");
  a_ready_rel: assert property (@(posedge clk_i) disable iff (!resetn_i)
    system_ready_o |-> hard_reset_n_oe_o && soft_reset_n_oe_o) else $error("ready in reset");
  // own drive of the pin must never look like an outside request
  a_self_ignored: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r_q.drv_hard && $past(r_q.drv_hard) |-> r_q.hin_cnt == 6'h0) else $error("self request");
  c_ready: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(system_ready_o));
  c_ext_reset: cover property (@(posedge clk_i) disable iff (!resetn_i)
    r_q.st == RINIT_RUN ##1 r_q.st == RINIT_ASSERT);
  c_strap_on: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(strap_drive_en_o));
endmodule // rinit_seq

// [src/rinit_pkg.sv]
// package for the reset initialization sequencer
package rinit_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned IN_RESET_MIN_SYNC = 32;
  localparam int unsigned OUT_ASSERT_MIN_SYNC = 512;
  localparam int unsigned HARD_TO_SOFT_SYNC = 16;
  localparam int unsigned STRAP_TURNON_SYNC = 1;
  localparam int unsigned STRAP_TURNOFF_NS = 4;
  localparam int unsigned PLL_LOCK_US = 100;
  localparam int unsigned PLL_LOCK_CYC = (PLL_LOCK_US * (CLK_HZ / 1000000));
  localparam int unsigned DLL_LOCK_MIN_CYC = 7680;
  localparam int unsigned DLL_LOCK_MAX_CYC = 122880;
  localparam int unsigned CNT_W = 17;
  localparam int unsigned BOOT_W = 3;
  localparam logic [BOOT_W-1:0] BOOT_RESET_VAL = 3'h0;
  localparam logic [1:0] SYNC_RESET_VAL = 2'h3;

  typedef enum logic [2:0] {
    RINIT_POR = 3'h0,
    RINIT_PLL = 3'h1,
    RINIT_DLL = 3'h3,
    RINIT_ASSERT = 3'h2,
    RINIT_SOFT = 3'h6,
    RINIT_RUN = 3'h7
  } rinit_state_type;

  typedef struct packed {
    logic [BOOT_W-1:0] boot_source;
    logic input_clock_divide_select;
  } rinit_strap_type;

  typedef struct packed {
    logic hard_n;
    logic soft_n;
  } rinit_rst_type;
endpackage

// [test/rinit_board.sv]
// board model: pulled-up open-drain reset pins and an external reset source
module rinit_board (
  input wire logic hard_oe_n_i,
  input wire logic soft_oe_n_i,
  input wire logic ext_hard_n_i,
  output wire rinit_pkg::rinit_rst_type pins_o
);
  import rinit_pkg::*;
  // wired-and with pull-up, so a released pin reads high, never the last value
  assign pins_o.hard_n = hard_oe_n_i & ext_hard_n_i;
  assign pins_o.soft_n = soft_oe_n_i;
endmodule // rinit_board

// [test/tb_top.sv]
// self-checking testbench for the reset initialization sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rinit_pkg::*;
  logic clk_i, resetn_i, host_mode_i, ext_hard_n, pll_lk, dll_lk, hard_oe_n, soft_oe_n, drive_en, tick, ready;
  logic [1:0] dll_ratio_sel_i;
  rinit_strap_type strap_i, strap_o;
  rinit_rst_type rst_pin;
  int bad_count, checks_done;
  rinit_board rinit_board_i (.hard_oe_n_i(hard_oe_n), .soft_oe_n_i(soft_oe_n), .ext_hard_n_i(ext_hard_n),
    .pins_o(rst_pin));
  rinit_seq rinit_seq_i (.clk_i(clk_i), .resetn_i(resetn_i), .host_mode_i(host_mode_i),
    .dll_ratio_sel_i(dll_ratio_sel_i), .pll_locked_i(pll_lk), .dll_locked_i(dll_lk), .strap_i(strap_i),
    .rst_pin_i(rst_pin), .hard_reset_n_oe_o(hard_oe_n), .soft_reset_n_oe_o(soft_oe_n),
    .strap_drive_en_o(drive_en), .sync_tick_o(tick), .strap_o(strap_o), .system_ready_o(ready));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic results();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // counts clk cycles of hard assertion and of the hard-to-soft gap
  task automatic seq_out(input int d, input int min_low);
    int hl, sl, n;
    hl = 0;
    sl = 0;
    n = 0;
    check("drive off in reset", 1'b0, drive_en);
    while (hard_oe_n !== 1'b1 && hl < 200000) begin @(negedge clk_i); hl++; end
    check("drive off at release", 1'b0, drive_en);
    while (soft_oe_n !== 1'b1 && sl < 200000) begin @(negedge clk_i); sl++; end
    check("hard low span", 1'b1, hl >= min_low);
    check("soft gap", 1'b1, sl >= 16 * d);
    while (drive_en !== 1'b1 && n < 8) begin @(negedge clk_i); n++; end
    check("drive back", 1'b1, n < 8);
  endtask
  task automatic boot(input logic host, input rinit_strap_type s, input logic pll, input int d, input int min_low);
    @(negedge clk_i);
    resetn_i = 1'b0;
    host_mode_i = host;
    pll_lk = pll;
    strap_i = s;
    repeat (6) @(negedge clk_i);
    resetn_i = 1'b1;
    @(negedge clk_i);
    strap_i = ~s;
    seq_out(d, min_low);
    check("latched straps", s, strap_o);
    check("ready", 1'b1, ready);
  endtask
  task automatic ticks(input logic [31:0] exp);
    logic [31:0] n;
    n = 0;
    repeat (20) begin @(negedge clk_i); n += tick; end
    check("sync ticks in 20 clocks", exp, n);
  endtask
  // external hard reset pulse of len clocks; short ones must be ignored
  task automatic pulse(input int len, input logic hit);
    int n, k;
    rinit_strap_type keep;
    keep = strap_o;
    n = 0;
    k = 0;
    ext_hard_n = 1'b0;
    repeat (len) begin @(negedge clk_i); k += (hard_oe_n === 1'b0); end
    ext_hard_n = 1'b1;
    while (hard_oe_n === 1'b1 && n < 40) begin @(negedge clk_i); n++; end
    check("reset taken", hit, n < 40);
    if (hit) begin
      seq_out(1, 512 - k);
      check("straps kept", keep, strap_o);
    end
  endtask
  initial begin
    #1000000;
    bad_count++;
    results();
  end
  initial begin
    resetn_i = 1'b0;
    host_mode_i = 1'b0;
    ext_hard_n = 1'b1;
    pll_lk = 1'b1;
    dll_lk = 1'b1;
    dll_ratio_sel_i = 2'h0;
    strap_i = 4'h0;
    bad_count = 0;
    checks_done = 0;
    boot(1'b0, 4'ha, 1'b1, 1, 512);
    ticks(20);
    pulse(20, 1'b0);
    pulse(40, 1'b1);
    boot(1'b1, 4'h5, 1'b0, 2, PLL_LOCK_CYC + 1024);
    ticks(10);
    dll_lk = 1'b0;
    boot(1'b0, 4'h3, 1'b1, 1, DLL_LOCK_MIN_CYC + 512);
    results();
  end
endmodule // tb_top
